// >>> include/did_map.svh
// Register offsets, field positions, function codes and reset values of the input decoder
`ifndef DID_MAP_SVH
`define DID_MAP_SVH

// Terminal count and function selector width
`define DID_NUM_TERM    9
`define DID_FSEL_W      6

// Register byte addresses (word aligned)
`define DID_ADDR_FSEL0  8'h00
`define DID_ADDR_CTRL   8'h24
`define DID_ADDR_STATUS 8'h28
`define DID_ADDR_MASK   8'h2C
`define DID_ADDR_STATE  8'h30
`define DID_ADDR_OFFSET 8'h34

// Terminal function codes
`define DID_FN_NONE     6'h00
`define DID_FN_COAST    6'h06
`define DID_FN_PAUSE    6'h07
`define DID_FN_RESET    6'h08
`define DID_FN_EXTF     6'h09
`define DID_FN_EXTF_NC  6'h0A
`define DID_FN_UP       6'h0B
`define DID_FN_DOWN     6'h0C
`define DID_FN_UDCLR    6'h0D
`define DID_FN_SRCSW    6'h0E
`define DID_FN_PRESET_A 6'h0F
`define DID_FN_PRESET_B 6'h10
`define DID_FN_MS1      6'h11
`define DID_FN_MS2      6'h12
`define DID_FN_MS3      6'h13
`define DID_FN_MS4      6'h14
`define DID_FN_ACC1     6'h15
`define DID_FN_ACC2     6'h16

// External fault number reported to the drive
`define DID_FAULT_EXT   8'h11

// Control register fields
`define DID_CTRL_W      6
`define DID_CTRL_DIGSRC 0
`define DID_CTRL_TWOSRC 1
`define DID_CTRL_DIGPRE 2
`define DID_CTRL_ACT_LO 4
`define DID_CTRL_RST    6'h01

// Status / mask bits
`define DID_STAT_W      7
`define DID_EV_RESET    0
`define DID_EV_FAULT    1
`define DID_EV_UP       2
`define DID_EV_DOWN     3
`define DID_EV_CLEAR    4
`define DID_EV_COAST    5
`define DID_EV_RESUME   6

// Frequency offset width and step
`define DID_OFS_W       16
`define DID_OFS_STEP    16'h0001

`endif

// >>> include/did_pkg.sv
// Types shared by the input decoder modules
`include "did_map.svh"
package did_pkg;
  // Function selector of one terminal
  typedef logic [`DID_FSEL_W-1:0] did_func_t;
  // Pause tracker states
  typedef enum logic [1:0] {DID_PS_FREE, DID_PS_HELD_RUN, DID_PS_HELD_IDLE} did_pause_t;
endpackage

// >>> include/did_term_if.sv
// Synchronised terminal levels and rising-edge pulses between the decoder modules
`timescale 1ns/10ps
`include "did_map.svh"
interface did_term_if;
  logic [`DID_NUM_TERM-1:0] level;  // Clean terminal level
  logic [`DID_NUM_TERM-1:0] rise;   // One-cycle rising-edge pulse
  modport src (output level, rise);
  modport dst (input level, rise);
endinterface

// >>> rtl/did_term_sync.sv
// Two-flop synchroniser and rising-edge detector for all input terminals
`timescale 1ns/10ps
`include "did_map.svh"
module did_term_sync
  import did_pkg::*;
(
  // Clock and synchronised reset
  input  wire logic                     clk,
  input  wire logic                     rstN,
  // Raw terminal pins
  input  wire logic [`DID_NUM_TERM-1:0] diPin,
  // Clean levels and edges
  did_term_if.src                       term
);

  logic [`DID_NUM_TERM-1:0] meta;  // First stage, read only by the second
  logic [`DID_NUM_TERM-1:0] sync;  // Second stage, safe to use
  logic [`DID_NUM_TERM-1:0] prev;  // Last clean level for edge detection

  // Pins are asynchronous, so two flops come before any logic
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      meta <= '0;
      sync <= '0;
      prev <= '0;
    end
    else
    begin
      meta <= diPin;  // RULE16
      sync <= meta;
      prev <= sync;
    end
  end

  // Levels act while held, edges once per rising transition
  assign term.level = sync;          // RULE16
  assign term.rise  = sync & ~prev;  // RULE16

endmodule

// >>> rtl/did_decoder_top.sv
// Digital input terminal function decoder with AHB-Lite register access
// How it works
// RULE1 - Each terminal selects function 0-63; zero inert
// RULE2 - Function 6 blocks output, motor coasts
// RULE3 - Function 7 pauses, keeping run state
// RULE4 - Releasing pause resumes previous running state
// RULE5 - Function 8 resets fault like keypad
// RULE6 - Function 9 edge raises fault 17
// RULE7 - Function 10 open contact raises fault 17
// RULE8 - Functions 11/12 step frequency when digital
// RULE9 - Function 13 clears up/down back to preset
// RULE10 - Function 14 picks one of two sources
// RULE11 - Function 15 substitutes preset for source A
// RULE12 - Function 16 substitutes preset for source B
// RULE13 - Functions 17-20 form multi-step speed code
// RULE14 - Acceleration select picks one of four sets
// RULE15 - Functions 21/22 form two-bit time selector
// RULE16 - Terminals sampled synchronously; levels and edges
// RULE17 - Outside holds levels stable several clocks
//
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps
`include "did_map.svh"
module did_decoder_top
  import did_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  // Terminal pins
  input  wire logic [`DID_NUM_TERM-1:0] diPin,
  // Drive status from the run logic
  input  wire logic                     runActive,
  input  wire logic                     keypadReset,
  // AHB-Lite slave
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic [31:0]                   hrdata,
  output logic                          hresp,
  // Run commands
  output logic                          coastStop,
  output logic                          runPause,
  output logic                          resumeRun,
  // Fault commands
  output logic                          faultReset,
  output logic                          faultActive,
  output logic [7:0]                    faultCode,
  output logic [1:0]                    faultAction,
  // Frequency commands
  output logic                          freqUp,
  output logic                          freqDown,
  output logic                          freqClear,
  output logic [`DID_OFS_W-1:0]         upDownOffset,
  output logic                          srcSelB,
  output logic                          presetForA,
  output logic                          presetForB,
  // Speed and ramp selection
  output logic [3:0]                    stepSel,
  output logic [1:0]                    accelSel,
  // Interrupt
  output logic                          irq
);

  logic                         rstMeta;   // Reset release, first stage
  logic                         rstN;      // Reset used by the design
  did_func_t                    fsel [`DID_NUM_TERM];  // Per-terminal function
  logic [`DID_CTRL_W-1:0]       ctrl;      // Control fields
  logic [`DID_STAT_W-1:0]       status;    // Sticky events
  logic [`DID_STAT_W-1:0]       mask;      // Interrupt enables
  logic [`DID_STAT_W-1:0]       events;    // Events this cycle
  did_pause_t                   pState;    // Pause tracker
  did_pause_t                   next_pState;
  logic                         wrPend;    // Write data phase pending
  logic                         rdPend;    // Read data phase pending
  logic [5:0]                   regIdx;    // Word index of the access
  logic [31:0]                  readMux;   // Read value of regIdx
  logic                         faultSet;  // External fault this cycle
  logic                         faultClr;  // Reset request this cycle

  // Decoded function levels and edges
  logic levCoast, levPause, levSrcSw, levPreA, levPreB, levNcOpen;
  logic rseReset, rseExtf, rseUp, rseDown, rseClr;
  logic [3:0] levMs;
  logic [1:0] levAcc;

  did_term_if term ();

  // Reset is released through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstMeta <= 1'b0;
      rstN    <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstN    <= rstMeta;
    end
  end

  // Pin synchroniser and edge detector
  did_term_sync uSync (
    .clk   (clk),
    .rstN  (rstN),
    .diPin (diPin),
    .term  (term)
  );

  // OR of all terminals assigned a function; code zero never matches here
  function automatic logic fnAny(input logic [`DID_NUM_TERM-1:0] v, input did_func_t f);
    logic r;
    r = 1'b0;
    for (int i = 0; i < `DID_NUM_TERM; i++)
      r = r | (v[i] & (fsel[i] == f));  // RULE1
    return r;
  endfunction

  // Function decode from clean levels and edges
  always_comb
  begin
    levCoast = fnAny(term.level, `DID_FN_COAST);
    levPause = fnAny(term.level, `DID_FN_PAUSE);
    levSrcSw = fnAny(term.level, `DID_FN_SRCSW);
    levPreA  = fnAny(term.level, `DID_FN_PRESET_A);
    levPreB  = fnAny(term.level, `DID_FN_PRESET_B);
    levMs    = {fnAny(term.level, `DID_FN_MS4), fnAny(term.level, `DID_FN_MS3),
                fnAny(term.level, `DID_FN_MS2), fnAny(term.level, `DID_FN_MS1)};  // RULE13
    levAcc   = {fnAny(term.level, `DID_FN_ACC2), fnAny(term.level, `DID_FN_ACC1)};  // RULE15
    // Normally closed contact: an open (low) terminal is the fault
    levNcOpen = fnAny(~term.level, `DID_FN_EXTF_NC);  // RULE7
    rseReset = fnAny(term.rise, `DID_FN_RESET);
    rseExtf  = fnAny(term.rise, `DID_FN_EXTF);
    rseUp    = fnAny(term.rise, `DID_FN_UP);
    rseDown  = fnAny(term.rise, `DID_FN_DOWN);
    rseClr   = fnAny(term.rise, `DID_FN_UDCLR);
  end

  assign faultSet = rseExtf | levNcOpen;      // RULE6 RULE7
  assign faultClr = rseReset | keypadReset;   // RULE5

  // Coast stop follows its terminal level directly
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      coastStop <= 1'b0;
    else
      coastStop <= levCoast;  // RULE2
  end

  // Pause tracker remembers whether the drive was running when paused
  always_comb
  begin
    next_pState = pState;
    unique case (pState)
      DID_PS_FREE:
        if (levPause)
          next_pState = runActive ? DID_PS_HELD_RUN : DID_PS_HELD_IDLE;  // RULE3
      DID_PS_HELD_RUN, DID_PS_HELD_IDLE:
        if (!levPause)
          next_pState = DID_PS_FREE;
    endcase
  end

  // Pause level and one-cycle resume pulse; run data is never cleared here
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      pState    <= DID_PS_FREE;
      runPause  <= 1'b0;
      resumeRun <= 1'b0;
    end
    else
    begin
      pState    <= next_pState;
      runPause  <= levPause;  // RULE3
      resumeRun <= (pState == DID_PS_HELD_RUN) && !levPause;  // RULE4
    end
  end

  // Fault latch; a new fault wins over a reset in the same cycle
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      faultActive <= 1'b0;
      faultCode   <= 8'h00;
      faultReset  <= 1'b0;
    end
    else
    begin
      faultReset <= faultClr;  // RULE5
      if (faultSet)
      begin
        faultActive <= 1'b1;             // RULE6 RULE7
        faultCode   <= `DID_FAULT_EXT;   // RULE6
      end
      else if (faultClr)
      begin
        faultActive <= 1'b0;  // RULE5
        faultCode   <= 8'h00;
      end
    end
  end

  // Up/down stepping only with the digital source; clear returns to preset
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      freqUp       <= 1'b0;
      freqDown     <= 1'b0;
      freqClear    <= 1'b0;
      upDownOffset <= '0;
    end
    else
    begin
      freqUp    <= rseUp & ctrl[`DID_CTRL_DIGSRC];    // RULE8
      freqDown  <= rseDown & ctrl[`DID_CTRL_DIGSRC];  // RULE8
      freqClear <= rseClr & ctrl[`DID_CTRL_DIGPRE];   // RULE9
      // Clear has priority so no stray step survives it
      if (rseClr && ctrl[`DID_CTRL_DIGPRE])
        upDownOffset <= '0;  // RULE9
      else if (ctrl[`DID_CTRL_DIGSRC] && rseUp && !rseDown)
        upDownOffset <= upDownOffset + `DID_OFS_STEP;  // RULE8
      else if (ctrl[`DID_CTRL_DIGSRC] && rseDown && !rseUp)
        upDownOffset <= upDownOffset - `DID_OFS_STEP;  // RULE8
    end
  end

  // Source selection, preset substitution, speed and ramp selectors
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      srcSelB     <= 1'b0;
      presetForA  <= 1'b0;
      presetForB  <= 1'b0;
      stepSel     <= 4'h0;
      accelSel    <= 2'h0;
      faultAction <= 2'h0;
    end
    else
    begin
      srcSelB     <= ctrl[`DID_CTRL_TWOSRC] & levSrcSw;  // RULE10
      presetForA  <= levPreA;  // RULE11
      presetForB  <= levPreB;  // RULE12
      stepSel     <= levMs;    // RULE13
      accelSel    <= levAcc;   // RULE14 RULE15
      faultAction <= ctrl[`DID_CTRL_ACT_LO +: 2];  // RULE6
    end
  end

  // Events collected for the status register
  always_comb
  begin
    events = '0;
    events[`DID_EV_RESET]  = faultClr;
    events[`DID_EV_FAULT]  = faultSet;
    events[`DID_EV_UP]     = rseUp & ctrl[`DID_CTRL_DIGSRC];
    events[`DID_EV_DOWN]   = rseDown & ctrl[`DID_CTRL_DIGSRC];
    events[`DID_EV_CLEAR]  = rseClr & ctrl[`DID_CTRL_DIGPRE];
    events[`DID_EV_COAST]  = levCoast & !coastStop;
    events[`DID_EV_RESUME] = (pState == DID_PS_HELD_RUN) && !levPause;
  end

  // AHB address phase capture; reads take one wait state, writes none
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      wrPend <= 1'b0;
      rdPend <= 1'b0;
      regIdx <= 6'h00;
    end
    else if (hready)
    begin
      wrPend <= hsel & htrans[1] & hwrite;
      rdPend <= hsel & htrans[1] & !hwrite;
      regIdx <= haddr[7:2];
    end
  end

  // Register read view; unmapped words read zero
  always_comb
  begin
    readMux = 32'h0000_0000;
    if (regIdx < 6'(`DID_NUM_TERM))
      readMux = {26'h0, fsel[regIdx[3:0]]};
    else if (regIdx == `DID_ADDR_CTRL >> 2)
      readMux = {26'h0, ctrl};
    else if (regIdx == `DID_ADDR_STATUS >> 2)
      readMux = {25'h0, status};
    else if (regIdx == `DID_ADDR_MASK >> 2)
      readMux = {25'h0, mask};
    else if (regIdx == `DID_ADDR_STATE >> 2)
      readMux = {12'h0, accelSel, stepSel, presetForB, presetForA, srcSelB,
                 faultActive, runPause, coastStop, faultCode};
    else if (regIdx == `DID_ADDR_OFFSET >> 2)
      readMux = {16'h0, upDownOffset};
  end

  // Ready and read data; the stall gives reads a registered data path
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end
    else
    begin
      hresp <= 1'b0;
      if (hready && hsel && htrans[1] && !hwrite)
        hreadyout <= 1'b0;
      else if (!hreadyout)
      begin
        hreadyout <= 1'b1;
        hrdata    <= readMux;
      end
    end
  end

  // Configuration writes; partial sizes treated as whole words
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      for (int i = 0; i < `DID_NUM_TERM; i++)
        fsel[i] <= `DID_FN_NONE;  // RULE1
      ctrl <= `DID_CTRL_RST;
      mask <= '0;
    end
    else if (wrPend && hready)
    begin
      if (regIdx < 6'(`DID_NUM_TERM))
        fsel[regIdx[3:0]] <= hwdata[`DID_FSEL_W-1:0];  // RULE1
      else if (regIdx == `DID_ADDR_CTRL >> 2)
        ctrl <= hwdata[`DID_CTRL_W-1:0];
      else if (regIdx == `DID_ADDR_MASK >> 2)
        mask <= hwdata[`DID_STAT_W-1:0];
    end
  end

  // Sticky status: write one to clear, a new event wins over the clear
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      status <= '0;
    else if (wrPend && hready && regIdx == `DID_ADDR_STATUS >> 2)
      status <= (status & ~hwdata[`DID_STAT_W-1:0]) | events;
    else
      status <= status | events;
  end

  // Level interrupt, one cycle behind the status bits
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      irq <= 1'b0;
    else
      irq <= |(status & mask);
  end

  // Checks of the decoded behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN);

  sequence s_pauseHeldRun;
    pState == DID_PS_HELD_RUN && levPause;
  endsequence

  sequence s_pauseRelease;
    !levPause;
  endsequence

  a_zero_inert: assert property (!levCoast |=> !coastStop)  // RULE1
    else $error("coast stop without an assigned active terminal");
  a_coast_follow: assert property (levCoast |=> coastStop)  // RULE2
    else $error("coast stop not asserted");
  a_pause_hold: assert property (levPause |=> runPause && pState != DID_PS_FREE)  // RULE3
    else $error("pause not held");
  a_pause_resume: assert property (s_pauseHeldRun ##1 s_pauseRelease |=> resumeRun ##1 !resumeRun)  // RULE4
    else $error("resume pulse missing after pause release");
  a_reset_pulse: assert property (rseReset && !faultSet |=> faultReset && !faultActive)  // RULE5
    else $error("terminal reset did not clear the fault");
  a_fault_code: assert property (rseExtf |=> faultActive && faultCode == 8'h11)  // RULE6
    else $error("external fault not reported as 17");
  a_nc_fault: assert property (levNcOpen |=> faultActive && faultCode == `DID_FAULT_EXT)  // RULE7
    else $error("open normally closed contact did not fault");
  a_updown_gate: assert property (!ctrl[`DID_CTRL_DIGSRC] && !(rseClr && ctrl[`DID_CTRL_DIGPRE])  // RULE8
                                  |=> !freqUp && !freqDown && $stable(upDownOffset))
    else $error("frequency stepped without digital source");
  a_updown_step: assert property (ctrl[`DID_CTRL_DIGSRC] && rseUp && !rseDown && !rseClr
                                  |=> upDownOffset == $past(upDownOffset) + 16'h0001)  // RULE8
    else $error("up step missing");
  a_clear_preset: assert property (rseClr && ctrl[`DID_CTRL_DIGPRE] |=> upDownOffset == 16'h0000 && freqClear)  // RULE9
    else $error("up/down clear failed");
  a_source_switch: assert property (!ctrl[`DID_CTRL_TWOSRC] |=> !srcSelB)  // RULE10
    else $error("source switched while not in two-source mode");
  a_preset_sub: assert property (##1 presetForA == $past(levPreA) && presetForB == $past(levPreB))  // RULE11 RULE12
    else $error("preset substitution does not follow terminals");
  a_speed_sel: assert property (##1 stepSel == $past(levMs) && accelSel == $past(levAcc))  // RULE13 RULE15
    else $error("speed or ramp selector mismatch");
  a_status_sticky: assert property (events[`DID_EV_FAULT] |=> status[`DID_EV_FAULT])  // RULE6
    else $error("fault event lost from status");

endmodule

// >>> test/did_switch_model.sv
// External switch and relay model that drives the decoder's terminal pins
`timescale 1ns/10ps
`include "did_map.svh"
module did_switch_model
  import did_pkg::*;
#(
  parameter int HOLD = 4  // Minimum clocks that a contact level stands
)
(
  // Clock
  input  wire logic                     clk,
  // Requested contact levels
  input  wire logic [`DID_NUM_TERM-1:0] want,
  // Contact levels at the pins
  output logic      [`DID_NUM_TERM-1:0] diPin
);
  int held;  // Clocks since the last level change

  // Start open with the hold already satisfied
  initial
  begin
    diPin = '0;
    held  = HOLD;
  end

  // Real contacts bounce, so a change is only passed on once the old level stood
  always @(posedge clk)
  begin
    if (want != diPin && held >= HOLD)
    begin
      diPin <= want;
      held  <= 0;
    end
    else if (held < HOLD)
      held <= held + 1;
  end
endmodule

// >>> test/tb_digital_input_function_decoder.sv
// Self-checking bench for the digital input function decoder
`timescale 1ns/10ps
`include "did_map.svh"
module tb_digital_input_function_decoder
  import did_pkg::*;
;
  // Clock, reset and drive status
  logic        clk;
  logic        arstN;
  logic        runActive;
  logic        keypadReset;
  // Terminals
  logic [8:0]  want;
  logic [8:0]  diPin;
  // Bus
  logic        hsel;
  logic        hwrite;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  // Decoder commands
  logic        coastStop, runPause, resumeRun, faultReset, faultActive, irq;
  logic        freqUp, freqDown, freqClear, srcSelB, presetForA, presetForB;
  logic [7:0]  faultCode;
  logic [1:0]  faultAction;
  logic [1:0]  accelSel;
  logic [3:0]  stepSel;
  logic [3:0]  code;
  logic [15:0] upDownOffset;
  // Pulse counts and bookkeeping
  int          nResume = 0;
  int          nReset = 0;
  int          nStep = 0;
  int          nClr = 0;
  int          mismatches = 0;
  int          nChecks = 0;
  // First and second terminal assignments
  did_func_t   fnA [9] = '{`DID_FN_COAST, `DID_FN_PAUSE, `DID_FN_RESET, `DID_FN_EXTF,
                           `DID_FN_UP, `DID_FN_DOWN, `DID_FN_UDCLR, `DID_FN_SRCSW,
                           `DID_FN_PRESET_A};
  did_func_t   fnB [9] = '{`DID_FN_MS1, `DID_FN_MS2, `DID_FN_MS3, `DID_FN_MS4,
                           `DID_FN_ACC1, `DID_FN_ACC2, `DID_FN_PRESET_B,
                           `DID_FN_EXTF_NC, `DID_FN_NONE};

  did_switch_model sw (.clk(clk), .want(want), .diPin(diPin));

  did_decoder_top uut (
    .clk(clk), .arst_n(arstN), .diPin(diPin), .runActive(runActive),
    .keypadReset(keypadReset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .coastStop(coastStop),
    .runPause(runPause), .resumeRun(resumeRun), .faultReset(faultReset),
    .faultActive(faultActive), .faultCode(faultCode), .faultAction(faultAction),
    .freqUp(freqUp), .freqDown(freqDown), .freqClear(freqClear),
    .upDownOffset(upDownOffset), .srcSelB(srcSelB), .presetForA(presetForA),
    .presetForB(presetForB), .stepSel(stepSel), .accelSel(accelSel), .irq(irq)
  );

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  // Count one-cycle command pulses; a stuck pulse shows as an excess count
  always @(posedge clk)
  begin
    nResume <= nResume + int'(resumeRun === 1'b1);
    nReset  <= nReset + int'(faultReset === 1'b1);
    nStep   <= nStep + int'(freqUp === 1'b1) + int'(freqDown === 1'b1);
    nClr    <= nClr + int'(freqClear === 1'b1);
  end

  // Compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    nChecks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // One single AHB-Lite transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h000000, a};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    // Address taken: data phase, wait states allowed
    htrans <= 2'h0;
    hwdata <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    chk(q, exp, what);
  endtask

  // Wait out contact hold, synchroniser and edge detector with margin
  task automatic settle;
    repeat (8) @(posedge clk);
  endtask

  task automatic pins(input logic [8:0] v);
    want <= v;
    settle();
  endtask

  // Verdict
  task automatic results;
    $display("Mismatches %0d, checks %0d", mismatches, nChecks);
    if (mismatches == 0 && nChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog well beyond the expected few hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end

  // Main sequence
  initial
  begin
    clk = 1'b0;
    arstN = 1'b0;
    want = 9'h000;
    runActive = 1'b0;
    keypadReset = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    repeat (5) @(posedge clk);
    arstN <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset values, unmapped and read-only space
    for (int i = 0; i < 9; i++)
      rdChk(`DID_ADDR_FSEL0 + 8'(4 * i), 32'h00000000, "fsel reset");
    rdChk(`DID_ADDR_CTRL, 32'h00000001, "ctrl reset");
    rdChk(8'h40, 32'h00000000, "unmapped read");
    wr(`DID_ADDR_STATE, 32'hFFFFFFFF);
    rdChk(`DID_ADDR_STATE, 32'h00000000, "state read only");
    chk(32'(hresp), 32'h00000000, "response");
    // Unassigned terminal is inert, then coast stop; coast event stays masked
    pins(9'h001);
    chk(32'(coastStop), 32'h00000000, "unassigned terminal");
    wr(`DID_ADDR_FSEL0, 32'(fnA[0]));
    settle();
    chk(32'({coastStop, irq}), 32'h00000002, "coast on, irq masked");
    rdChk(`DID_ADDR_STATE, 32'h00000100, "state coast");
    pins(9'h000);
    chk(32'(coastStop), 32'h00000000, "coast off");
    for (int i = 1; i < 9; i++)
      wr(`DID_ADDR_FSEL0 + 8'(4 * i), 32'(fnA[i]));
    // Pause while running resumes once; pause from idle does not
    runActive <= 1'b1;
    pins(9'h002);
    chk(32'(runPause), 32'h00000001, "pause");
    pins(9'h000);
    chk(32'(nResume), 32'h00000001, "resume pulse");
    runActive <= 1'b0;
    pins(9'h002);
    pins(9'h000);
    chk(32'(nResume), 32'h00000001, "no resume from idle");
    // Terminal and keypad fault reset, one pulse per edge
    pins(9'h004);
    pins(9'h000);
    chk(32'(nReset), 32'h00000001, "terminal reset");
    keypadReset <= 1'b1;
    @(posedge clk);
    keypadReset <= 1'b0;
    settle();
    chk(32'(nReset), 32'h00000002, "keypad reset");
    // External fault pulse with interrupt enabled
    wr(`DID_ADDR_MASK, 32'h00000002);
    wr(`DID_ADDR_CTRL, 32'h00000031);
    wr(`DID_ADDR_STATUS, 32'h0000007F);
    pins(9'h008);
    pins(9'h000);
    chk(32'({faultActive, faultCode, faultAction}), 32'h00000447, "ext fault");
    chk(32'(irq), 32'h00000001, "fault irq");
    rdChk(`DID_ADDR_STATUS, 32'h00000002, "fault status");
    wr(`DID_ADDR_STATUS, 32'h00000002);
    settle();
    chk(32'({irq, faultActive}), 32'h00000001, "irq cleared, fault held");
    pins(9'h004);
    pins(9'h000);
    chk(32'({faultActive, faultCode}), 32'h00000000, "fault reset");
    // Up and down steps with digital source, then refused without it
    pins(9'h010);
    pins(9'h000);
    pins(9'h010);
    pins(9'h000);
    pins(9'h020);
    pins(9'h000);
    chk(32'(upDownOffset), 32'h00000001, "up up down");
    rdChk(`DID_ADDR_OFFSET, 32'h00000001, "offset reg");
    wr(`DID_ADDR_CTRL, 32'h00000000);
    pins(9'h010);
    pins(9'h000);
    pins(9'h040);
    pins(9'h000);
    chk(32'({nStep[3:0], nClr[3:0], upDownOffset}), 32'h00300001, "refused");
    wr(`DID_ADDR_CTRL, 32'h00000005);
    pins(9'h040);
    pins(9'h000);
    chk(32'({nClr[3:0], upDownOffset}), 32'h00010000, "clear");
    // Source switch needs two-source mode; preset for source A
    pins(9'h180);
    chk(32'({srcSelB, presetForA}), 32'h00000001, "single source");
    wr(`DID_ADDR_CTRL, 32'h00000007);
    settle();
    chk(32'(srcSelB), 32'h00000001, "source B");
    // Closed contact first, then normally-closed fault and speed selectors
    pins(9'h0C0);
    for (int i = 0; i < 9; i++)
      wr(`DID_ADDR_FSEL0 + 8'(4 * i), 32'(fnB[i]));
    settle();
    chk(32'({presetForB, faultActive}), 32'h00000002, "preset B, contact closed");
    for (int c = 0; c < 16; c++)
    begin
      code = 4'(c);
      pins({3'b011, code[1:0], code});
      chk(32'(stepSel), 32'(code), "step select");
      chk(32'(accelSel), 32'(code[1:0]), "ramp select");
    end
    pins(9'h040);
    chk(32'({faultActive, faultCode}), 32'h00000111, "contact opened");
    results();
  end
endmodule
